// ===== ohpt_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the
  overheat pin timer monitor. Assumes a 200 MHz core clock.
*/
`ifndef OHPT_CFG_SVH
`define OHPT_CFG_SVH

// register indices; byte address is four times the index
`define OHPT_R1_CFG 8'h5F
`define OHPT_LOC_CFG 8'h60
`define OHPT_R2_CFG 8'h61
`define OHPT_R1_CRIT 8'h6A
`define OHPT_LOC_CRIT 8'h6B
`define OHPT_R2_CRIT 8'h6C
`define OHPT_STATUS2 8'h42
`define OHPT_MASK2 8'h75
`define OHPT_CFG3 8'h78
`define OHPT_TIMER 8'h79
`define OHPT_LIMIT 8'h7A
`define OHPT_CFG4 8'h7D

// field positions
`define OHPT_ALERT_BIT 0
`define OHPT_EV_EN_BIT 1
`define OHPT_MAX_FAN_OVERRIDE_BIT 2
`define OHPT_ALT_ALERT_BIT 0
`define OHPT_SEL_BIT 1
`define OHPT_F4P_BIT 5
`define OHPT_OUT_EN_BIT 3

// reset value of every register
`define OHPT_REG_RST 8'h00

// timer resolution: 22.76 ms in microseconds, clock period in ns
`define OHPT_TICK_US 22760
`define OHPT_CLK_NS 5
`define OHPT_TICK_CYC (`OHPT_TICK_US * 1000 / `OHPT_CLK_NS)

`endif

// ===== ohpt_event_src.sv
/*
  Far side of one event pin: a processor hot output or trip sensor.
  Assumes an open-drain pin with a pull-up, device enable active low.
*/
`default_nettype none
module ohpt_event_src
(
  // far side request to pull the pin low
  input wire logic pullLow,
  // device side open-drain enable
  input wire logic devOeN,
  // resolved pin level
  output logic level
);
  // wired-and; pull-up wins once both let go, never a stale value
  assign level = !(pullLow || !devOeN);
endmodule
`default_nettype wire

// ===== ohpt_monitor.sv
/*
  Overheat event pin timer and monitor with an Avalon-MM slave.
  Assumes temperatures, monitoring-cycle strobes and fan run state
  come from logic on clk; the pins come from outside and are
  synchronised here. Pins are open drain, resolved outside.
*/
// Chosen here: the Avalon-MM register port.
`include "ohpt_cfg.svh"
`default_nettype none

// What this block does
// - alert-on-alt-pin bit routes the alert to the second alert pin.
// - event function only when enabled; select picks exactly one pin.
// - select clear uses the tach-four pin; set frees it as tach.
// - override bit forces full duty on running fans while event is low.
// - override does nothing for a fan that is stopped.
// - timer runs while asserted, pauses otherwise, accumulates.
// - eight-bit timer saturates at full scale until cleared.
// - reading the timer returns it, then clears it.
// - bit 0 on first assertion; from two ticks on it counts ticks.
// - read during assertion clears, sets bit 0, counts from zero.
// - such a read with limit zero sets the event flag again.
// - timer above limit sets status bit 5 and raises the alert.
// - limit zero alerts at first assertion; one after two ticks.
// - mask bit 5 suppresses the alert but not the flag.
// - event pin drive decisions change only once per monitoring cycle.
// - three critical limits and three channel enable bits.
// - flags stay set until condition ended and status is read.
// - alert stays low while the unmasked condition persists.
module ohpt_monitor
  import ohpt_pkg::*;
#(
  parameter int TICK_CYCLES = `OHPT_TICK_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // tach-four pin, default event pin
  input wire logic pin14In,
  output logic pin14Out,
  output logic pin14OeN,
  // alternate event pin
  input wire logic pin20In,
  output logic pin20Out,
  output logic pin20OeN,
  // alert pins, open drain
  output logic alert10Out,
  output logic alert10OeN,
  output logic alert22Out,
  output logic alert22OeN,
  // tach path and fan control
  output logic fourthTachInput,
  input wire logic [2:0] fanRunning,
  output logic [2:0] fanFullDuty,
  // temperatures, quarter degree steps, strobed per monitoring cycle
  input wire logic [9:0] remote1Temp,
  input wire logic [9:0] localTemp,
  input wire logic [9:0] remote2Temp,
  input wire logic [2:0] measDone
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  ohpt_bus_e busState;
  ohpt_byte_t chanCfg [3];
  ohpt_byte_t critLimit [3];
  ohpt_byte_t mask2, cfg3, cfg4, limit;
  ohpt_byte_t ticks;
  logic seen, eventFlag;
  logic s14a, s14b, s20a, s20b;
  logic [TW-1:0] subCount;
  logic [2:0] hot;
  logic driving;
  logic [2:0] driveHist; // own drive still echoes through pin and sync
  logic evEnable, evSel, evLow, tick, over, alertAct;
  logic ackRd, ackWr, timerRd, statusRd;
  logic [7:0] idx, timerVal, wdat;
  logic [9:0] temps [3];

  // visible timer: bit 0 alone until two ticks are reached
  function automatic logic [7:0] shownTimer(input logic [7:0] t,
                                             input logic s);
    shownTimer = (t < 8'h02 && s) ? 8'h01 : t;
  endfunction

  assign temps[0] = remote1Temp;
  assign temps[1] = localTemp;
  assign temps[2] = remote2Temp;
  assign idx = avs_address[9:2]; // word index, byte lanes ignored
  assign wdat = avs_writedata[7:0];
  assign ackRd = busState == OHPT_ACK && avs_read;
  assign ackWr = busState == OHPT_ACK && avs_write;
  assign timerRd = ackRd && idx == `OHPT_TIMER;
  assign statusRd = ackRd && idx == `OHPT_STATUS2;

  // one wait state on every access
  assign avs_waitrequest = (avs_read || avs_write) &&
                           busState != OHPT_ACK;

  // answer cycle follows the request cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busState <= OHPT_IDLE;
    else if (busState == OHPT_ACK)
      busState <= OHPT_IDLE;
    else if (avs_read || avs_write)
      busState <= OHPT_ACK;
  end

  // read data captured in the request cycle; unmapped reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h00000000;
    else if (busState == OHPT_IDLE && avs_read)
    begin
      case (idx)
        `OHPT_R1_CFG: avs_readdata <= {24'h000000, chanCfg[0]};
        `OHPT_LOC_CFG: avs_readdata <= {24'h000000, chanCfg[1]};
        `OHPT_R2_CFG: avs_readdata <= {24'h000000, chanCfg[2]};
        `OHPT_R1_CRIT: avs_readdata <= {24'h000000, critLimit[0]};
        `OHPT_LOC_CRIT: avs_readdata <= {24'h000000, critLimit[1]};
        `OHPT_R2_CRIT: avs_readdata <= {24'h000000, critLimit[2]};
        `OHPT_STATUS2:
          avs_readdata <= {26'h0000000, eventFlag, 5'h00};
        `OHPT_MASK2: avs_readdata <= {24'h000000, mask2};
        `OHPT_CFG3: avs_readdata <= {24'h000000, cfg3};
        `OHPT_TIMER: avs_readdata <= {24'h000000, timerVal};
        `OHPT_LIMIT: avs_readdata <= {24'h000000, limit};
        `OHPT_CFG4: avs_readdata <= {24'h000000, cfg4};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // software-written registers, taken in the answer cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chanCfg <= '{`OHPT_REG_RST, `OHPT_REG_RST, `OHPT_REG_RST};
      critLimit <= '{`OHPT_REG_RST, `OHPT_REG_RST, `OHPT_REG_RST};
      mask2 <= `OHPT_REG_RST;
      cfg3 <= `OHPT_REG_RST;
      cfg4 <= `OHPT_REG_RST;
      limit <= `OHPT_REG_RST;
    end
    else if (ackWr)
    begin
      case (idx)
        `OHPT_R1_CFG: chanCfg[0] <= wdat;
        `OHPT_LOC_CFG: chanCfg[1] <= wdat;
        `OHPT_R2_CFG: chanCfg[2] <= wdat;
        `OHPT_R1_CRIT: critLimit[0] <= wdat;
        `OHPT_LOC_CRIT: critLimit[1] <= wdat;
        `OHPT_R2_CRIT: critLimit[2] <= wdat;
        `OHPT_MASK2: mask2 <= wdat;
        `OHPT_CFG3: cfg3 <= wdat;
        `OHPT_CFG4: cfg4 <= wdat;
        `OHPT_LIMIT: limit <= wdat;
        default: ;
      endcase
    end
  end

  // pin synchronisers, second stage only is read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s14a <= 1'b1;
      s14b <= 1'b1;
      s20a <= 1'b1;
      s20b <= 1'b1;
    end
    else
    begin
      s14a <= pin14In;
      s14b <= s14a;
      s20a <= pin20In;
      s20b <= s20a;
    end
  end

  // our own pull-down is not counted as an external event
  assign evEnable = cfg3[`OHPT_EV_EN_BIT];
  assign evSel = cfg4[`OHPT_SEL_BIT];
  assign evLow = evEnable && !driving && driveHist == 3'b000 &&
                 (evSel ? !s20b : !s14b);
  assign tick = evLow && subCount == TICK_LAST;
  assign timerVal = shownTimer(ticks, seen);
  assign over = seen && timerVal > limit;
  assign alertAct = eventFlag && !mask2[`OHPT_F4P_BIT];

  // resolution divider, paused while the input is negated
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      subCount <= '0;
    else if (evLow)
      subCount <= tick ? '0 : subCount + TW'(1);
  end

  // accumulated ticks; a read restarts from zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ticks <= 8'h00;
      seen <= 1'b0;
    end
    else if (timerRd)
    begin
      ticks <= 8'h00;
      seen <= evLow;
    end
    else
    begin
      if (evLow)
        seen <= 1'b1;
      if (tick && ticks != 8'hFF)
        ticks <= ticks + 8'h01;
    end
  end

  // sticky flag: a new exceedance wins over the read clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      eventFlag <= 1'b0;
    else if (over)
      eventFlag <= 1'b1;
    else if (statusRd)
      eventFlag <= 1'b0;
  end

  // per-channel hot state, updated once per monitoring cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hot <= 3'b000;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (measDone[i])
          hot[i] <= temps[i] > {critLimit[i], 2'b00};
      end
    end
  end

  // pin drivers, registered; enables are active low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      driving <= 1'b0;
      driveHist <= 3'b000;
      pin14OeN <= 1'b1;
      pin20OeN <= 1'b1;
      alert10OeN <= 1'b1;
      alert22OeN <= 1'b1;
    end
    else
    begin
      driving <= evEnable && |(hot & {chanCfg[2][`OHPT_OUT_EN_BIT],
                 chanCfg[1][`OHPT_OUT_EN_BIT],
                 chanCfg[0][`OHPT_OUT_EN_BIT]});
      driveHist <= {driveHist[1:0], driving};
      pin14OeN <= !(driving && !evSel);
      pin20OeN <= !(driving && evSel);
      alert10OeN <= !(alertAct && cfg3[`OHPT_ALERT_BIT]);
      alert22OeN <= !(alertAct &&
                      cfg4[`OHPT_ALT_ALERT_BIT]);
    end
  end

  // open drain: level is always low, enable does the work
  assign pin14Out = 1'b0;
  assign pin20Out = 1'b0;
  assign alert10Out = 1'b0;
  assign alert22Out = 1'b0;
  // tach path idles high while the pin carries the event
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fourthTachInput <= 1'b1;
    else
      fourthTachInput <= (evEnable && !evSel) ? 1'b1 : s14b;
  end
  // full duty only for running fans
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fanFullDuty <= 3'b000;
    else if (cfg3[`OHPT_MAX_FAN_OVERRIDE_BIT] && evLow)
      fanFullDuty <= fanRunning;
    else
      fanFullDuty <= 3'b000;
  end
  property p_sat;
    @(posedge clk) disable iff (!nrst)
    ticks == 8'hFF && !timerRd |=> ticks == 8'hFF;
  endproperty
  a_sat: assert property (p_sat)
    else $error("timer left full scale without read");
  property p_rdclr;
    @(posedge clk) disable iff (!nrst)
    timerRd |=> ticks == 8'h00 && seen == $past(evLow);
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("timer read did not clear");
  property p_pause;
    @(posedge clk) disable iff (!nrst)
    !evLow && !timerRd |=> $stable(ticks);
  endproperty
  a_pause: assert property (p_pause)
    else $error("timer moved while negated");
  property p_flag;
    @(posedge clk) disable iff (!nrst)
    over |=> eventFlag;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag not set on exceedance");
  property p_sticky;
    @(posedge clk) disable iff (!nrst)
    eventFlag && !statusRd |=> eventFlag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without status read");
  sequence s_alert_cause;
    eventFlag && !mask2[5] && cfg4[0];
  endsequence
  property p_alert;
    @(posedge clk) disable iff (!nrst)
    s_alert_cause ##1 s_alert_cause |-> !alert22OeN;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert pin not pulled low");
  property p_mask;
    @(posedge clk) disable iff (!nrst)
    mask2[5] ##1 mask2[5] |-> alert10OeN && alert22OeN;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked alert driven");
  property p_max_fan_override;
    @(posedge clk) disable iff (!nrst)
    !cfg3[2] |=> fanFullDuty == 3'b000;
  endproperty
  a_max_fan_override: assert property (p_max_fan_override)
    else $error("full duty without override");
  property p_hold;
    @(posedge clk) disable iff (!nrst)
    measDone == 3'b000 |=> $stable(hot);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hot state changed between cycles");
endmodule
`default_nettype wire

// ===== ohpt_pkg.sv
/*
  Types of the overheat pin timer monitor.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ohpt_pkg;
  typedef logic [7:0] ohpt_byte_t;
  // bus slave: request seen, then one answer cycle
  typedef enum logic {OHPT_IDLE, OHPT_ACK} ohpt_bus_e;
endpackage
`default_nettype wire

// ===== ohpt_tb.sv
/*
  Self-checking bench for the overheat pin timer monitor.
  Assumes the design files and ohpt_event_src alongside.
*/
`include "ohpt_cfg.svh"
`default_nettype none
module tb
  import ohpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 8;
  logic clk = 1'b0, nrst = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic [9:0] avsAddress = '0, r1T = '0, locT = '0, r2T = '0;
  logic [31:0] avsWritedata = '0, avsReaddata;
  logic avsWaitrequest, p14Out, p14OeN, p20Out, p20OeN, fourth_tach_input;
  logic a10Out, a10OeN, a22Out, a22OeN, lvl14, lvl20;
  logic pull14 = 1'b0, pull20 = 1'b0;
  logic [2:0] fanRun = '0, fanFull, measDone = '0;
  int mismatches = 0, testsRun = 0;

  // short tick keeps the saturation run near two thousand cycles
  ohpt_monitor #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .nrst(nrst),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .pin14In(lvl14),
    .pin14Out(p14Out), .pin14OeN(p14OeN), .pin20In(lvl20),
    .pin20Out(p20Out), .pin20OeN(p20OeN), .alert10Out(a10Out),
    .alert10OeN(a10OeN), .alert22Out(a22Out), .alert22OeN(a22OeN),
    .fourthTachInput(fourth_tach_input), .fanRunning(fanRun), .fanFullDuty(fanFull),
    .remote1Temp(r1T), .localTemp(locT), .remote2Temp(r2T),
    .measDone(measDone));
  ohpt_event_src hot14_u (.pullLow(pull14), .devOeN(p14OeN),
    .level(lvl14));
  ohpt_event_src hot20_u (.pullLow(pull20), .devOeN(p20OeN),
    .level(lvl20));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer, held until waitrequest is seen low at a rising edge;
  // entered just after a rise, data taken at that same edge
  task automatic bus(input logic w, input ohpt_byte_t idx,
    input ohpt_byte_t d, output logic [31:0] q);
    int n;
    n = 0;
    avsWrite <= w;
    avsRead <= !w;
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {24'h000000, d};
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    // a slave that never answers counts against the run
    if (n >= 50)
      mismatches++;
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input ohpt_byte_t idx, input ohpt_byte_t d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input string what, input ohpt_byte_t idx,
    input ohpt_byte_t exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(what, {24'h000000, exp}, q);
  endtask

  // pull the chosen pin low, then let the synchroniser drain
  task automatic hold(input logic alt, input int n);
    if (alt) pull20 <= 1'b1; else pull14 <= 1'b1;
    repeat (n) @(posedge clk);
    pull14 <= 1'b0;
    pull20 <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs();
    ohpt_byte_t ix [10] = '{8'h5F, 8'h60, 8'h61, 8'h6A, 8'h6B, 8'h6C,
      8'h75, 8'h78, 8'h7A, 8'h7D};
    foreach (ix[i])
    begin
      rd("reset", ix[i], 8'h00);
      wr(ix[i], 8'hA5);
      rd("rw", ix[i], 8'hA5);
      wr(ix[i], 8'h00);
    end
    wr(8'h10, 8'hFF);
    rd("unmapped", 8'h10, 8'h00);
    rd("timer reset", `OHPT_TIMER, 8'h00);
  endtask

  task automatic t_timer();
    hold(1'b0, 20);
    rd("disabled", `OHPT_TIMER, 8'h00);
    wr(`OHPT_CFG3, 8'h02);
    chk("tach held", 1'b1, fourth_tach_input);
    hold(1'b0, 3);
    rd("first", `OHPT_TIMER, 8'h01);
    rd("cleared", `OHPT_TIMER, 8'h00);
    hold(1'b0, 24);
    hold(1'b0, 24);
    rd("accum", `OHPT_TIMER, 8'h06);
    hold(1'b1, 20);
    rd("other pin", `OHPT_TIMER, 8'h00);
    wr(`OHPT_CFG4, 8'h02);
    hold(1'b0, 20);
    rd("freed", `OHPT_TIMER, 8'h00);
    pull14 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("tach free", 1'b0, fourth_tach_input);
    pull14 <= 1'b0;
    hold(1'b1, 3);
    rd("alt pin", `OHPT_TIMER, 8'h01);
    wr(`OHPT_CFG4, 8'h00);
    rd("status set", `OHPT_STATUS2, 8'h20);
    rd("status clr", `OHPT_STATUS2, 8'h00);
  endtask

  task automatic t_sat();
    wr(`OHPT_LIMIT, 8'hFF);
    hold(1'b0, 2100);
    rd("saturate", `OHPT_TIMER, 8'hFF);
    rd("no flag", `OHPT_STATUS2, 8'h00);
    wr(`OHPT_LIMIT, 8'h00);
    pull14 <= 1'b1;
    repeat (4) @(posedge clk);
    rd("read busy", `OHPT_TIMER, 8'h01);
    rd("flag again", `OHPT_STATUS2, 8'h20);
    pull14 <= 1'b0;
    repeat (4) @(posedge clk);
    rd("after", `OHPT_TIMER, 8'h01);
    rd("clr", `OHPT_STATUS2, 8'h20);
    rd("clr done", `OHPT_STATUS2, 8'h00);
  endtask

  task automatic t_alert();
    logic [31:0] q;
    wr(`OHPT_LIMIT, 8'h01);
    wr(`OHPT_CFG3, 8'h03);
    wr(`OHPT_CFG4, 8'h01);
    hold(1'b0, 6);
    chk("below", 1'b1, a10OeN);
    rd("below st", `OHPT_STATUS2, 8'h00);
    hold(1'b0, 20);
    chk("alert", 1'b0, a10OeN);
    chk("alt alert", 1'b0, a22OeN);
    rd("flag", `OHPT_STATUS2, 8'h20);
    chk("still", 1'b0, a10OeN);
    bus(1'b0, `OHPT_TIMER, 8'h00, q);
    rd("clr", `OHPT_STATUS2, 8'h20);
    repeat (2) @(posedge clk);
    chk("gone", 1'b1, a10OeN);
    wr(`OHPT_MASK2, 8'h20);
    hold(1'b0, 30);
    chk("masked", 1'b1, a10OeN);
    rd("masked st", `OHPT_STATUS2, 8'h20);
    bus(1'b0, `OHPT_TIMER, 8'h00, q);
    rd("clr2", `OHPT_STATUS2, 8'h20);
    rd("clr2 done", `OHPT_STATUS2, 8'h00);
    wr(`OHPT_MASK2, 8'h00);
    wr(`OHPT_CFG4, 8'h00);
  endtask

  task automatic t_max_fan_override();
    fanRun <= 3'b101;
    wr(`OHPT_CFG3, 8'h06);
    pull14 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("max_fan_override", 3'b101, fanFull);
    chk("tach busy", 1'b1, fourth_tach_input);
    pull14 <= 1'b0;
    repeat (5) @(posedge clk);
    chk("max_fan_override off", 3'b000, fanFull);
    wr(`OHPT_CFG3, 8'h02);
    pull14 <= 1'b1;
    repeat (5) @(posedge clk);
    chk("no max_fan_override", 3'b000, fanFull);
    pull14 <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] m);
    measDone <= m;
    @(posedge clk);
    measDone <= 3'b000;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_out();
    logic [31:0] q;
    wr(`OHPT_LOC_CFG, 8'h08);
    wr(`OHPT_LOC_CRIT, 8'h50);
    // empty the timer so our own drive would show up in it
    bus(1'b0, `OHPT_TIMER, 8'h00, q);
    r1T <= 10'h3FF;
    pulse(3'b001);
    chk("off chan", 1'b1, p14OeN);
    locT <= 10'h141;
    pulse(3'b010);
    chk("drive", 1'b0, p14OeN);
    locT <= 10'h140;
    repeat (20) @(posedge clk);
    chk("held", 1'b0, p14OeN);
    pulse(3'b010);
    chk("release", 1'b1, p14OeN);
    wr(`OHPT_CFG4, 8'h02);
    locT <= 10'h141;
    pulse(3'b010);
    chk("drive alt", 1'b0, p20OeN);
    chk("alt only", 1'b1, p14OeN);
    chk("od level", 4'h0, {p14Out, p20Out, a10Out, a22Out});
    locT <= 10'h140;
    pulse(3'b010);
    chk("release alt", 1'b1, p20OeN);
    repeat (4) @(posedge clk);
    rd("own pull", `OHPT_TIMER, 8'h00);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, well beyond the roughly two thousand seven hundred cycles used
  initial
  begin
    #100000;
    mismatches++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_timer();
    t_sat();
    t_alert();
    t_max_fan_override();
    t_out();
    results();
  end
endmodule
`default_nettype wire
